// [core/buffer_powerdown_alarm_pin_config.sv]
// register bank for buffer power-down, offset alarm setup and status pins
`timescale 1ns/10ps
module buffer_powerdown_alarm_pin_config (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // status from the clock core
    input wire logic lockLoss,
    input wire logic irqStatus,
    input wire logic in1BadStatus,
    input wire logic in2BadStatus,
    // polarity bits, 0 active low
    input wire logic lockLossPolarity,
    input wire logic irqPolarity,
    input wire logic inputBadPolarity,
    // buffer power control
    output logic out1Disable,
    output logic out2Disable,
    output logic out1LowspeedDividerPd,
    output logic out2LowspeedDividerPd,
    output logic in1Powerdown,
    output logic in2Powerdown,
    // alarm setup
    output logic freqOffsetGlobalEnable,
    output logic [1:0] freqOffsetThreshold,
    output logic [1:0] alarmClearDelay,
    output logic [2:0] lockOneshotInterval,
    output logic lockOneshotUndefined,
    // status pins, oe low while driving
    output logic in2BadOutput,
    output logic in2BadOutputOe_n,
    output logic irqOrIn1BadOutput,
    output logic irqOrIn1BadOutputOe_n,
    output logic lockLossOutput,
    output logic lockLossOutputOe_n
);

    // -----------------------------------------------------------------
    // register storage
    // -----------------------------------------------------------------
    logic [7:0] outDsbl_r;
    logic [7:0] inPd_r;
    logic [7:0] alarmCfg_r;
    logic [7:0] pinEn_r;

    // -----------------------------------------------------------------
    // write decode
    // -----------------------------------------------------------------
    // one strobe per register
    logic wrOutDsbl;
    logic wrInPd;
    logic wrAlarmCfg;
    logic wrPinEn;

    // qualified by clock enable so a frozen bank ignores the host
    function automatic logic wrHit(input logic en, input logic wr, input logic [7:0] addr,
                                   input logic [7:0] target);
        wrHit = en && wr && (addr == target);
    endfunction : wrHit

    assign wrOutDsbl = wrHit(clkEn, regWrEn, regAddr, alarm_cfg_pkg::ADDR_OUT_DSBL);
    assign wrInPd = wrHit(clkEn, regWrEn, regAddr, alarm_cfg_pkg::ADDR_IN_PD);
    assign wrAlarmCfg = wrHit(clkEn, regWrEn, regAddr, alarm_cfg_pkg::ADDR_ALARM_CFG);
    assign wrPinEn = wrHit(clkEn, regWrEn, regAddr, alarm_cfg_pkg::ADDR_PIN_EN);

    // masked write keeps reserved bits at reset value
    function automatic logic [7:0] mergeWrite(input logic [7:0] cur, input logic [7:0] wd,
                                              input logic [7:0] mask);
        mergeWrite = (cur & ~mask) | (wd & mask);
    endfunction : mergeWrite

    // polarity: active high passes, active low inverts
    function automatic logic applyPol(input logic stat, input logic pol);
        applyPol = pol ? stat : ~stat;
    endfunction : applyPol

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outDsbl_r <= alarm_cfg_pkg::RST_OUT_DSBL;
        end else if (wrOutDsbl) begin
            outDsbl_r <= mergeWrite(outDsbl_r, regWrData, alarm_cfg_pkg::WMASK_OUT_DSBL);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inPd_r <= alarm_cfg_pkg::RST_IN_PD;
        end else if (wrInPd) begin
            inPd_r <= mergeWrite(inPd_r, regWrData, alarm_cfg_pkg::WMASK_IN_PD);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarmCfg_r <= alarm_cfg_pkg::RST_ALARM_CFG;
        end else if (wrAlarmCfg) begin
            alarmCfg_r <= mergeWrite(alarmCfg_r, regWrData, alarm_cfg_pkg::WMASK_ALARM_CFG);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinEn_r <= alarm_cfg_pkg::RST_PIN_EN;
        end else if (wrPinEn) begin
            pinEn_r <= mergeWrite(pinEn_r, regWrData, alarm_cfg_pkg::WMASK_PIN_EN);
        end
    end

    // -----------------------------------------------------------------
    // read port, one cycle latency; unmapped addresses read zero
    // -----------------------------------------------------------------
    logic [7:0] rdData_nxt;

    always_comb begin
        unique case (regAddr)
            alarm_cfg_pkg::ADDR_OUT_DSBL: rdData_nxt = outDsbl_r;
            alarm_cfg_pkg::ADDR_IN_PD: rdData_nxt = inPd_r;
            alarm_cfg_pkg::ADDR_ALARM_CFG: rdData_nxt = alarmCfg_r;
            alarm_cfg_pkg::ADDR_PIN_EN: rdData_nxt = pinEn_r;
            default: rdData_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdValid <= 1'b0;
        end else if (clkEn) begin
            regRdValid <= regRdEn;
        end
    end

    // data holds between reads so the host may sample it late
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (clkEn && regRdEn) begin
            regRdData <= rdData_nxt;
        end
    end

    // -----------------------------------------------------------------
    // buffer power and alarm setup outputs, registered copies
    // -----------------------------------------------------------------
    logic [7:0] outDsbl_nxt;
    logic [7:0] inPd_nxt;
    logic [7:0] alarmCfg_nxt;

    // outputs follow the register one cycle later, from reset value on
    assign outDsbl_nxt = outDsbl_r;
    assign inPd_nxt = inPd_r;
    assign alarmCfg_nxt = alarmCfg_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out1Disable <= alarm_cfg_pkg::RST_OUT_DSBL[alarm_cfg_pkg::OUT1_DIS_BIT];
            out2Disable <= alarm_cfg_pkg::RST_OUT_DSBL[alarm_cfg_pkg::OUT2_DIS_BIT];
            out1LowspeedDividerPd <= alarm_cfg_pkg::RST_OUT_DSBL[alarm_cfg_pkg::OUT1_DIS_BIT];
            out2LowspeedDividerPd <= alarm_cfg_pkg::RST_OUT_DSBL[alarm_cfg_pkg::OUT2_DIS_BIT];
        end else if (clkEn) begin
            // divider power-down tracks the buffer disable in disable mode
            out2Disable <= outDsbl_nxt[alarm_cfg_pkg::OUT2_DIS_BIT];
            out2LowspeedDividerPd <= outDsbl_nxt[alarm_cfg_pkg::OUT2_DIS_BIT];
            out1Disable <= outDsbl_nxt[alarm_cfg_pkg::OUT1_DIS_BIT];
            out1LowspeedDividerPd <= outDsbl_nxt[alarm_cfg_pkg::OUT1_DIS_BIT];
        end
    end

    // input buffers kept apart: they gate the references, not the outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in1Powerdown <= alarm_cfg_pkg::RST_IN_PD[alarm_cfg_pkg::IN1_PD_BIT];
            in2Powerdown <= alarm_cfg_pkg::RST_IN_PD[alarm_cfg_pkg::IN2_PD_BIT];
        end else if (clkEn) begin
            in2Powerdown <= inPd_nxt[alarm_cfg_pkg::IN2_PD_BIT];
            in1Powerdown <= inPd_nxt[alarm_cfg_pkg::IN1_PD_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            freqOffsetThreshold <=
                alarm_cfg_pkg::RST_ALARM_CFG[alarm_cfg_pkg::THR_HI:alarm_cfg_pkg::THR_LO];
            alarmClearDelay <=
                alarm_cfg_pkg::RST_ALARM_CFG[alarm_cfg_pkg::VAL_HI:alarm_cfg_pkg::VAL_LO];
            lockOneshotInterval <=
                alarm_cfg_pkg::RST_ALARM_CFG[alarm_cfg_pkg::LOCK_ONESHOT_INTERVAL_HI:alarm_cfg_pkg::LOCK_ONESHOT_INTERVAL_LO];
        end else if (clkEn) begin
            // thresholds and times are only configuration for the core
            freqOffsetThreshold <=
                alarmCfg_nxt[alarm_cfg_pkg::THR_HI:alarm_cfg_pkg::THR_LO];
            alarmClearDelay <=
                alarmCfg_nxt[alarm_cfg_pkg::VAL_HI:alarm_cfg_pkg::VAL_LO];
            lockOneshotInterval <=
                alarmCfg_nxt[alarm_cfg_pkg::LOCK_ONESHOT_INTERVAL_HI:alarm_cfg_pkg::LOCK_ONESHOT_INTERVAL_LO];
        end
    end

    // per-input enables live elsewhere; this only gates them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            freqOffsetGlobalEnable <= alarm_cfg_pkg::RST_ALARM_CFG[alarm_cfg_pkg::FREQ_OFFSET_GLOBAL_ENABLE_BIT];
        end else if (clkEn) begin
            freqOffsetGlobalEnable <= alarmCfg_nxt[alarm_cfg_pkg::FREQ_OFFSET_GLOBAL_ENABLE_BIT];
        end
    end

    // interval codes with no defined duration
    function automatic logic isUndefCode(input logic [2:0] code);
        isUndefCode = (code == alarm_cfg_pkg::LOCK_ONESHOT_INTERVAL_UNDEF)
                      || (code > alarm_cfg_pkg::LOCK_ONESHOT_INTERVAL_3MS3);
    endfunction : isUndefCode

    // undefined or unlisted codes flagged; core behaviour then is unspecified
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockOneshotUndefined <= 1'b0;
        end else if (clkEn) begin
            lockOneshotUndefined <=
                isUndefCode(alarmCfg_nxt[alarm_cfg_pkg::LOCK_ONESHOT_INTERVAL_HI:alarm_cfg_pkg::LOCK_ONESHOT_INTERVAL_LO]);
        end
    end

    // -----------------------------------------------------------------
    // status pins
    // -----------------------------------------------------------------
    logic sharedDrive_nxt;
    logic sharedLevel_nxt;

    always_comb begin
        sharedDrive_nxt = 1'b0;
        sharedLevel_nxt = 1'b0;
        if (pinEn_r[alarm_cfg_pkg::IRQ_PIN_BIT]) begin
            sharedDrive_nxt = 1'b1;
            sharedLevel_nxt = applyPol(irqStatus, irqPolarity);
        end else if (pinEn_r[alarm_cfg_pkg::IN1_BAD_PIN_BIT]) begin
            sharedDrive_nxt = 1'b1;
            sharedLevel_nxt = applyPol(in1BadStatus, inputBadPolarity);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in2BadOutput <= 1'b0;
            in2BadOutputOe_n <= 1'b1;
        end else if (clkEn) begin
            // level kept valid while released, only oe_n follows the enable
            in2BadOutputOe_n <= ~pinEn_r[alarm_cfg_pkg::IN2_BAD_PIN_BIT];
            in2BadOutput <= applyPol(in2BadStatus, inputBadPolarity);
        end
    end

    // shared pin: irq has priority over in1 bad when both are enabled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqOrIn1BadOutput <= 1'b0;
            irqOrIn1BadOutputOe_n <= 1'b1;
        end else if (clkEn) begin
            irqOrIn1BadOutputOe_n <= ~sharedDrive_nxt;
            irqOrIn1BadOutput <= sharedLevel_nxt;
        end
    end

    // lock-loss pin
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockLossOutput <= 1'b0;
            lockLossOutputOe_n <= 1'b1;
        end else if (clkEn) begin
            lockLossOutputOe_n <= ~pinEn_r[alarm_cfg_pkg::LOCK_LOSS_PIN_ENABLE_BIT];
            lockLossOutput <= applyPol(lockLoss, lockLossPolarity);
        end
    end

endmodule : buffer_powerdown_alarm_pin_config

// [common/alarm_cfg_pkg.sv]
// constants for the buffer power-down, alarm and status pin control registers
package alarm_cfg_pkg;
    localparam logic [7:0] ADDR_OUT_DSBL = 8'h0a;
    localparam logic [7:0] ADDR_IN_PD = 8'h0b;
    localparam logic [7:0] ADDR_ALARM_CFG = 8'h13;
    localparam logic [7:0] ADDR_PIN_EN = 8'h14;
    localparam logic [7:0] RST_OUT_DSBL = 8'h00;
    localparam logic [7:0] RST_IN_PD = 8'h40;
    localparam logic [7:0] RST_ALARM_CFG = 8'h2c;
    localparam logic [7:0] RST_PIN_EN = 8'h3e;
    // writable bit masks; all other bits keep their reset value
    localparam logic [7:0] WMASK_OUT_DSBL = 8'h0c;
    localparam logic [7:0] WMASK_IN_PD = 8'h03;
    localparam logic [7:0] WMASK_ALARM_CFG = 8'hff;
    localparam logic [7:0] WMASK_PIN_EN = 8'h0f;
    // field positions
    localparam int OUT2_DIS_BIT = 3;
    localparam int OUT1_DIS_BIT = 2;
    localparam int IN2_PD_BIT = 1;
    localparam int IN1_PD_BIT = 0;
    localparam int FREQ_OFFSET_GLOBAL_ENABLE_BIT = 7;
    localparam int THR_HI = 6;
    localparam int THR_LO = 5;
    localparam int VAL_HI = 4;
    localparam int VAL_LO = 3;
    localparam int LOCK_ONESHOT_INTERVAL_HI = 2;
    localparam int LOCK_ONESHOT_INTERVAL_LO = 0;
    localparam int IN2_BAD_PIN_BIT = 3;
    localparam int IN1_BAD_PIN_BIT = 2;
    localparam int LOCK_LOSS_PIN_ENABLE_BIT = 1;
    localparam int IRQ_PIN_BIT = 0;
    // lock one-shot interval codes
    localparam logic [2:0] LOCK_ONESHOT_INTERVAL_106MS = 3'h0;
    localparam logic [2:0] LOCK_ONESHOT_INTERVAL_26MS5 = 3'h1;
    localparam logic [2:0] LOCK_ONESHOT_INTERVAL_UNDEF = 3'h2;
    localparam logic [2:0] LOCK_ONESHOT_INTERVAL_13MS3 = 3'h3;
    localparam logic [2:0] LOCK_ONESHOT_INTERVAL_6MS6 = 3'h4;
    localparam logic [2:0] LOCK_ONESHOT_INTERVAL_3MS3 = 3'h5;
endpackage : alarm_cfg_pkg

// [testbench/cfg_bank_monitor.sv]
// assertion checker for the power-down, alarm and pin register bank
`timescale 1ns/10ps
module cfg_bank_monitor (
    // clock and register port
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    // lock-loss pin
    input wire logic lockLoss,
    input wire logic lockLossPolarity,
    input wire logic lockLossOutput,
    // controls
    input wire logic out1Disable,
    input wire logic out2Disable,
    input wire logic out1LowspeedDividerPd,
    input wire logic out2LowspeedDividerPd,
    input wire logic freqOffsetGlobalEnable,
    input wire logic [1:0] freqOffsetThreshold,
    input wire logic [1:0] alarmClearDelay,
    input wire logic [2:0] lockOneshotInterval,
    input wire logic lockOneshotUndefined
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    out_disable_a: assert property (
        clkEn && regWrEn && regAddr == alarm_cfg_pkg::ADDR_OUT_DSBL ##1 clkEn |=>
        {out2Disable, out1Disable, out2LowspeedDividerPd, out1LowspeedDividerPd}
        == {$past(regWrData[3:2], 2), $past(regWrData[3:2], 2)})
        else $error("output disable does not follow write");
    alarm_fields_a: assert property (
        clkEn && regWrEn && regAddr == alarm_cfg_pkg::ADDR_ALARM_CFG ##1 clkEn |=>
        {freqOffsetGlobalEnable, freqOffsetThreshold, alarmClearDelay, lockOneshotInterval}
        == $past(regWrData, 2))
        else $error("alarm fields do not follow write");
    alarm_readback_a: assert property (
        clkEn && regRdEn && regAddr == alarm_cfg_pkg::ADDR_ALARM_CFG |=> regRdValid &&
        regRdData == {freqOffsetGlobalEnable, freqOffsetThreshold, alarmClearDelay,
        lockOneshotInterval})
        else $error("alarm readback differs from fields");
    undef_code_a: assert property (lockOneshotUndefined ==
        (lockOneshotInterval == 3'h2 || lockOneshotInterval[2:1] == 2'h3))
        else $error("undefined interval flag wrong");
    reserved_read_a: assert property (
        clkEn && regRdEn && regAddr == alarm_cfg_pkg::ADDR_IN_PD |=> regRdData[7:2] == 6'h10)
        else $error("reserved input power-down bits wrong");
    unmapped_read_a: assert property (
        clkEn && regRdEn && !(regAddr inside {8'h0a, 8'h0b, 8'h13, 8'h14}) |=>
        regRdValid && regRdData == 8'h00)
        else $error("unmapped read not zero");
    lol_level_a: assert property (
        clkEn |=> lockLossOutput == ($past(lockLoss) ~^ $past(lockLossPolarity)))
        else $error("lock-loss pin level wrong");
    frozen_state_a: assert property (
        !clkEn |=> $stable(out2Disable) && $stable(freqOffsetThreshold) && $stable(regRdValid))
        else $error("state moved while clock enable low");
endmodule : cfg_bank_monitor

bind buffer_powerdown_alarm_pin_config cfg_bank_monitor i_cfg_bank_monitor (.sys_clk, .rst_n,
    .clkEn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid, .lockLoss,
    .lockLossPolarity, .lockLossOutput, .out1Disable, .out2Disable, .out1LowspeedDividerPd,
    .out2LowspeedDividerPd, .freqOffsetGlobalEnable, .freqOffsetThreshold, .alarmClearDelay,
    .lockOneshotInterval, .lockOneshotUndefined);

// [testbench/buffer_powerdown_alarm_pin_config_tb.sv]
// self-checking bench for the power-down, alarm and pin register bank
`timescale 1ns/10ps
module buffer_powerdown_alarm_pin_config_tb;
    // ------------------------------------------------------------
    // stimulus and hookup
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic regRdValid;
    logic [3:0] stat = 4'h0;
    logic [2:0] pol = 3'h0;
    logic [1:0] outDis, outDiv, inPd, thr, clrDly;
    logic fosEn, undef;
    logic [2:0] lock_oneshot_interval;
    logic [5:0] pins;
    int n_fail = 0;
    int cmp_count = 0;
    always #12.5 sys_clk = ~sys_clk;
    buffer_powerdown_alarm_pin_config i_buffer_powerdown_alarm_pin_config (
        .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .lockLoss(stat[3]), .irqStatus(stat[2]), .in1BadStatus(stat[1]), .in2BadStatus(stat[0]),
        .lockLossPolarity(pol[2]), .irqPolarity(pol[1]), .inputBadPolarity(pol[0]),
        .out1Disable(outDis[0]), .out2Disable(outDis[1]), .out1LowspeedDividerPd(outDiv[0]),
        .out2LowspeedDividerPd(outDiv[1]), .in1Powerdown(inPd[0]), .in2Powerdown(inPd[1]),
        .freqOffsetGlobalEnable(fosEn), .freqOffsetThreshold(thr), .alarmClearDelay(clrDly),
        .lockOneshotInterval(lock_oneshot_interval), .lockOneshotUndefined(undef),
        .in2BadOutput(pins[5]), .in2BadOutputOe_n(pins[4]), .irqOrIn1BadOutput(pins[3]),
        .irqOrIn1BadOutputOe_n(pins[2]), .lockLossOutput(pins[1]), .lockLossOutputOe_n(pins[0]));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // waits two extra edges: derived outputs lag the register by one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1;
        chk("rdValid", 8'h01, {7'h00, regRdValid});
        chk("rdData", exp, regRdData);
    endtask : rd
    // dedicated pin levels stay valid while released; a released shared pin idles low
    function automatic logic [7:0] pinExp(input logic [3:0] e);
        pinExp = {2'b00, stat[0] ~^ pol[0], !e[3],
            e[0] ? stat[2] ~^ pol[1] : (e[2] ? stat[1] ~^ pol[0] : 1'b0),
            !(e[0] | e[2]), stat[3] ~^ pol[2], !e[1]};
    endfunction : pinExp
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h40);
        rd(8'h13, 8'h2c);
        rd(8'h14, 8'h3e);
        chk("resetPins", pinExp(4'he), {2'b00, pins});
        rd(8'h55, 8'h00);
        $display("test reset finished");
        for (int i = 0; i < 4; i++) begin
            v = 8'(i);
            wr(8'h0a, 8'hf3 | (v << 2));
            rd(8'h0a, v << 2);
            chk("outDisable", {4'h0, v[1:0], v[1:0]}, {4'h0, outDis, outDiv});
            wr(8'h0b, 8'hfc | v);
            rd(8'h0b, 8'h40 | v);
            chk("inPowerdown", v, {6'h00, inPd});
        end
        $display("test power finished");
        for (int i = 0; i < 8; i++) begin
            v = 8'(i);
            v = {v[0], v[1:0], v[2:1], v[2:0]};
            wr(8'h13, v);
            rd(8'h13, v);
            chk("fields", v, {fosEn, thr, clrDly, lock_oneshot_interval});
            chk("undef", {7'h00, i == 2 || i >= 6}, {7'h00, undef});
        end
        wr(8'h13, 8'h21);
        chk("recommended", 8'h01, {5'h00, lock_oneshot_interval});
        $display("test alarm finished");
        for (int i = 0; i < 16; i++) begin
            stat <= 4'(i) ^ 4'h5;
            pol <= 3'(i);
            wr(8'h14, 8'hf0 | 8'(i));
            rd(8'h14, 8'h30 | 8'(i));
            chk("pins", pinExp(4'(i)), {2'b00, pins});
        end
        $display("test pins finished");
        clkEn <= 1'b0;
        wr(8'h0a, 8'h00);
        chk("frozen", 8'h0f, {4'h0, outDis, outDiv});
        clkEn <= 1'b1;
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h13, 8'h2c);
        rd(8'h0a, 8'h00);
        $display("test freeze and reset finished");
        conclude();
    end
    // full run needs about 6 us; over fifteen times that is a hang
    initial begin
        #100us;
        n_fail++;
        conclude();
    end
endmodule : buffer_powerdown_alarm_pin_config_tb
